/* inc/sram_ctrl_pkg.sv */
// Package for the asynchronous 1M x 4 static memory controller
package sram_ctrl_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 4;
  localparam int CLK_PS = 4000;
  // Grade timing in picoseconds, fastest grade by default
  localparam int CYCLE_PS = 10000;
  localparam int ADDR_VALID_PS = 8000;
  localparam int SEL_LOW_PS = 8000;
  localparam int DATA_VALID_BEFORE_END_PS = 6000;
  localparam int WE_TO_HIZ_PS = 6000;
  localparam int OE_ACCESS_PS = 5000;
  localparam int DESELECT_HIZ_PS = 5000;
  // Least times round up, in clock cycles
  localparam int CYC_CYCLES = (CYCLE_PS + CLK_PS - 1) / CLK_PS;
  localparam int ACCESS_CYCLES = (CYCLE_PS + CLK_PS - 1) / CLK_PS;
  localparam int HIZ_CYCLES = (WE_TO_HIZ_PS + CLK_PS - 1) / CLK_PS;
  localparam int DVE_CYCLES = (DATA_VALID_BEFORE_END_PS + CLK_PS - 1) / CLK_PS;
  localparam int WP_A = (ADDR_VALID_PS + CLK_PS - 1) / CLK_PS;
  localparam int WP_B = HIZ_CYCLES + DVE_CYCLES;
  localparam int WP_CYCLES = (WP_A > WP_B) ? WP_A : WP_B;
  localparam int GAP_CYCLES = (DESELECT_HIZ_PS + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W = 4;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_t;

  typedef struct packed {
    logic selN;
    logic writeN;
    logic gateN;
    logic [ADDR_W-1:0] addr;
  } pins_t;
endpackage

/* src/pin_sync.sv */
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  wire [W-1:0] agree = ~(s2 ^ s3);
  wire [W-1:0] next_dout = (agree & s3) | (~agree & dout);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      dout <= '0;
    end else if (clkEn) begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end
endmodule

/* src/sram_host_ctrl.sv */
// Controller that drives the asynchronous 1M x 4 static memory through its pins
`timescale 1ns/1ps
// Contract
// R1: Memory holds 1M words of 4 bits, 20 address lines, 4 bidirectional data pins.
// R2: Memory is static and clockless; no refresh is ever issued.
// R3: Select low, strobe high, gate low makes memory drive read data.
// R4: Memory writes while select and strobe are both low.
// R5: Select high floats memory pins and ignores strobe and gate.
// R6: Read cycle, write cycle and access time equal the grade time.
// R7: Data valid at most gate access time after gate falls.
// R8: Old data held at least 4 ns after an address change.
// R9: Memory drives no sooner than 4 ns after select falls.
// R10: Address valid at least 8 or 10 ns before write ends.
// R11: Select low at least 8 or 10 ns before write ends.
// R12: Write data valid at least 6 or 7 ns before write ends.
// R13: Memory floats pins within 6 or 7 ns after strobe falls.
// R14: Memory drives no sooner than 3 ns after write ends.
// R15: Strobe low time covers turn-off delay plus data valid time.
// R16: Controller never drives pins while memory may still drive them.
// R17: Select falling with or after strobe keeps memory pins floating.
// R18: Late address delays read data by full access time from address.
// R19: Strobe returns high before the address changes.
module sram_host_ctrl #(
  parameter int CYC = sram_ctrl_pkg::CYC_CYCLES,
  parameter int ACC = sram_ctrl_pkg::ACCESS_CYCLES,
  parameter int WPW = sram_ctrl_pkg::WP_CYCLES,
  parameter int GAP = sram_ctrl_pkg::GAP_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic reqValid,
  input sram_ctrl_pkg::req_t req,
  output logic reqReady,
  output logic rdValid,
  output logic [sram_ctrl_pkg::DATA_W-1:0] rdData,
  output sram_ctrl_pkg::pins_t pins,
  input wire logic [sram_ctrl_pkg::DATA_W-1:0] dataIn,
  output logic [sram_ctrl_pkg::DATA_W-1:0] dataOut,
  output logic dataOe
);
  typedef enum logic [2:0] {IDLE, RD, WR_SETUP, WR_PULSE, WR_END, TURN} state_t;
  localparam logic [sram_ctrl_pkg::CNT_W-1:0] ONE = 4'h1;

  state_t state;
  state_t next_state;
  logic [sram_ctrl_pkg::CNT_W-1:0] cnt;
  logic [sram_ctrl_pkg::CNT_W-1:0] next_cnt;
  logic [sram_ctrl_pkg::DATA_W-1:0] dataSync;

  function automatic logic [sram_ctrl_pkg::CNT_W-1:0] cyc(input int n);
    cyc = (n < 1) ? ONE : n[sram_ctrl_pkg::CNT_W-1:0];
  endfunction

  // Read data arrives from the pins, so it goes through the synchroniser
  pin_sync #(.W(sram_ctrl_pkg::DATA_W)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .din(dataIn),
    .dout(dataSync)
  );

  wire cntDone = (cnt == ONE);
  wire take = (state == IDLE) && reqValid && reqReady;
  // Sync latency is four edges to dout; three cycles are added to the access time before sampling
  wire [sram_ctrl_pkg::CNT_W-1:0] rdLen = cyc(ACC + 3);

  always_comb begin
    next_state = state;
    next_cnt = cntDone ? cnt : cnt - ONE;
    case (state)
      IDLE: begin
        if (take) begin
          next_state = req.write ? WR_SETUP : RD;
          next_cnt = req.write ? ONE : rdLen;
        end
      end
      RD: begin
        if (cntDone) begin
          next_state = TURN;
          next_cnt = cyc(GAP);
        end
      end
      WR_SETUP: begin
        next_state = WR_PULSE;
        next_cnt = cyc(WPW);
      end
      WR_PULSE: begin
        if (cntDone) begin
          next_state = WR_END;
          next_cnt = cyc(CYC - WPW - 1);
        end
      end
      WR_END: begin
        if (cntDone) begin
          next_state = IDLE;
        end
      end
      TURN: begin
        if (cntDone) begin
          next_state = IDLE;
        end
      end
      default: begin
        next_state = IDLE;
        next_cnt = ONE;
      end
    endcase
  end

  // Gate is held high through writes so memory never drives during one
  wire next_selN = !(next_state == RD || next_state == WR_SETUP ||
    next_state == WR_PULSE || next_state == WR_END); // R5 R11
  wire next_writeN = !(next_state == WR_PULSE); // R4 R15 R19
  wire next_gateN = !(next_state == RD); // R3 R16
  // Data drive opens with strobe, gate already high, and ends a cycle after it
  wire next_dataOe = (next_state == WR_PULSE) || (next_state == WR_END); // R12 R16

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= IDLE;
      cnt <= ONE;
      pins <= '{selN: 1'b1, writeN: 1'b1, gateN: 1'b1, addr: '0};
      dataOut <= '0;
      dataOe <= 1'b0;
      reqReady <= 1'b0;
      rdValid <= 1'b0;
      rdData <= '0;
    end else if (clkEn) begin
      state <= next_state;
      cnt <= next_cnt;
      pins.selN <= next_selN;
      pins.writeN <= next_writeN;
      pins.gateN <= next_gateN;
      if (take) begin
        pins.addr <= req.addr; // R10 R18 R19
        dataOut <= req.wdata;
      end
      dataOe <= next_dataOe;
      reqReady <= (next_state == IDLE);
      rdValid <= (state == RD) && cntDone; // R6 R7 R18
      if ((state == RD) && cntDone) begin
        rdData <= dataSync;
      end
    end
  end

  a_strobe_inside_select: assert property (@(posedge mclk) disable iff (!rst_n)
    !pins.writeN |-> !pins.selN) else $error("Strobe low outside select"); // R11
  a_no_fight: assert property (@(posedge mclk) disable iff (!rst_n)
    dataOe |-> pins.gateN) else $error("Drive while gate low"); // R16
  a_addr_stable_write: assert property (@(posedge mclk) disable iff (!rst_n)
    !pins.writeN |-> $stable(pins.addr)) else $error("Address moved in write"); // R19
  a_pulse_width: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(pins.writeN) |-> !pins.writeN [*2]) else $error("Strobe too short"); // R15
  a_data_before_end: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(pins.writeN) |-> $past(dataOe) && $past(dataOe, 2))
    else $error("Data not valid before end"); // R12
  a_sel_before_end: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(pins.writeN) |-> !$past(pins.selN, 3)) else $error("Select too late"); // R11
  a_read_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    !pins.gateN |-> pins.writeN && !pins.selN) else $error("Bad read pins"); // R3
  a_read_done: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(pins.gateN) |-> ##[1:10] rdValid) else $error("Read never ends"); // R6

  // Cycle counts below assume the package defaults for the fastest grade

  a_pulse_full: assert property (@(posedge mclk) disable iff (!rst_n) // R15
    $fell(pins.writeN) |-> !pins.writeN [*4])
    else $error("Strobe shorter than turn-off plus data time");

  a_turn_gap: assert property (@(posedge mclk) disable iff (!rst_n) // R16
    $rose(pins.gateN) |-> !dataOe [*3])
    else $error("Drive too soon after read");

  a_data_hold_end: assert property (@(posedge mclk) disable iff (!rst_n) // R12
    $rose(pins.writeN) |-> dataOe)
    else $error("Data dropped at end of write");

  a_addr_move_idle: assert property (@(posedge mclk) disable iff (!rst_n) // R19
    $changed(pins.addr) |-> $past(pins.selN))
    else $error("Address moved while selected");

  a_oe_in_write: assert property (@(posedge mclk) disable iff (!rst_n) // R16
    dataOe |-> !pins.selN)
    else $error("Drive outside select");

  a_oe_after_strobe: assert property (@(posedge mclk) disable iff (!rst_n) // R16
    $rose(dataOe) |-> !pins.writeN)
    else $error("Drive opened before strobe");

  a_sel_setup: assert property (@(posedge mclk) disable iff (!rst_n) // R11
    $fell(pins.writeN) |-> $past(!pins.selN))
    else $error("Select not ahead of strobe");

  a_addr_setup: assert property (@(posedge mclk) disable iff (!rst_n) // R10
    $fell(pins.writeN) |-> $stable(pins.addr))
    else $error("Address not settled at strobe");

  a_ready_idle: assert property (@(posedge mclk) disable iff (!rst_n) // R16
    reqReady |-> pins.selN && pins.writeN && pins.gateN && !dataOe)
    else $error("Ready while pins busy");

  a_read_len: assert property (@(posedge mclk) disable iff (!rst_n) // R18
    $fell(pins.gateN) |-> !pins.gateN [*6])
    else $error("Read gate too short");

  a_valid_pulse: assert property (@(posedge mclk) disable iff (!rst_n) // R6
    rdValid |=> !rdValid)
    else $error("Read valid longer than a cycle");

  a_write_ends_sel: assert property (@(posedge mclk) disable iff (!rst_n) // R19
    $rose(pins.selN) |-> pins.writeN)
    else $error("Select left with strobe low");

  a_gap_after_sel: assert property (@(posedge mclk) disable iff (!rst_n) // R16
    $rose(pins.selN) |-> !dataOe)
    else $error("Drive left on after deselect");

  a_rdvalid_sel: assert property (@(posedge mclk) disable iff (!rst_n) // R6
    rdValid |-> pins.selN && pins.gateN)
    else $error("Read result before pins released");
endmodule

/* verification/sram_model.sv */
// Behavioural model of the asynchronous 1M x 4 static memory
`timescale 1ns/1ps
module sram_model (
  input wire logic mclk,
  input sram_ctrl_pkg::pins_t pins,
  input wire logic [3:0] dataOut,
  input wire logic dataOe,
  output logic [3:0] bus
);
  logic [3:0] mem [bit [19:0]];
  logic [3:0] last = 4'h0;
  logic [3:0] hold = 4'h0;
  logic wasW = 1'b0;
  wire rdOn = !pins.selN && pins.writeN && !pins.gateN;
  wire #4 rdLate = rdOn;
  // Turn-on waits, turn-off is immediate
  wire drv = rdOn && rdLate;
  wire wOn = !pins.selN && !pins.writeN;
  wire [3:0] q = mem.exists(pins.addr) ? mem[pins.addr] : 4'h0;
  wire [3:0] qLate;
  // Old word lingers a while after an address change
  assign #4 qLate = q;
  // Released lines flip each cycle so a stale value is never seen
  assign bus = (dataOe && drv) ? 4'hx : dataOe ? dataOut : drv ? qLate : ~last;
  always @(posedge mclk) begin
    last <= bus;
    if (wOn) hold <= bus;
    if (wasW && !wOn) mem[pins.addr] = hold;
    wasW <= wOn;
  end
endmodule

/* verification/sram_host_ctrl_bench.sv */
// Self-checking bench for the memory controller against a behavioural memory
`timescale 1ns/1ps
module sram_host_ctrl_bench;
  logic mclk = 0;
  logic rst_n = 0;
  logic clkEn = 1;
  logic reqValid = 0;
  sram_ctrl_pkg::req_t req = '0;
  logic reqReady, rdValid, dataOe;
  logic [3:0] rdData, dataOut, dataIn;
  sram_ctrl_pkg::pins_t pins;
  int fails = 0;
  int n_compared = 0;
  int seed = 79282;
  int cyc = 0;
  int i;
  logic [3:0] ref_q [int];
  logic [19:0] adr [$];
  always #2 mclk = ~mclk;
  sram_host_ctrl DUT (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .reqValid(reqValid),
    .req(req), .reqReady(reqReady), .rdValid(rdValid), .rdData(rdData), .pins(pins),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe));
  sram_model mem (.mclk(mclk), .pins(pins), .dataOut(dataOut), .dataOe(dataOe), .bus(dataIn));
  task wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Generous ceiling: each access takes seven to nine enabled cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end
  task access(input logic w, input logic [19:0] a, input logic [3:0] d);
    int k;
    logic [3:0] e;
    @(negedge mclk);
    for (k = 0; k < 50 && reqReady !== 1'b1; k++) @(negedge mclk);
    reqValid = 1;
    req = '{w, a, d};
    @(negedge mclk);
    reqValid = 0;
    if (w) ref_q[a] = d;
    else begin
      e = ref_q.exists(a) ? ref_q[a] : 4'h0;
      for (k = 0; k < 40 && rdValid !== 1'b1; k++) @(negedge mclk);
      n_compared++;
      if (rdValid !== 1'b1 || rdData !== e) begin
        fails++;
        $display("FAIL %0t got %h exp %h", $time, rdData, e);
      end
    end
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    rst_n = 1;
    adr.push_back(20'h00000);
    adr.push_back(20'hfffff);
    for (i = 0; i < 6; i++) adr.push_back($random(seed));
    foreach (adr[j]) access(1, adr[j], $random(seed));
    for (i = adr.size() - 1; i >= 0; i--) access(0, adr[i], 4'h0);
    $display("Test fill and readback done");
    access(1, adr[2], 4'ha);
    access(0, adr[2], 4'h0);
    access(0, 20'h12345, 4'h0);
    $display("Test back-to-back done");
    fork
      access(0, adr[1], 4'h0);
      begin
        repeat (3) @(negedge mclk);
        clkEn = 0;
        repeat (4) @(negedge mclk);
        clkEn = 1;
      end
    join
    $display("Test clock pause done");
    wrap_up();
  end
endmodule
